/* common/cpu_decode_pkg.sv */
// constants and types shared by the opcode decoder
package cpu_decode_pkg;
  localparam logic [7:0] OP_IDX_TO_SP = 8'h94;
  localparam logic [7:0] OP_WAIT_INT = 8'h8f;
  localparam logic [7:0] OP_PAGE2 = 8'h9e;
  localparam logic [7:0] OP_BSR = 8'had;
  localparam logic [7:0] OP_PUSH_A = 8'h87;
  localparam logic [7:0] OP_PUSH_X = 8'h89;
  localparam logic [7:0] OP_PUSH_H = 8'h8b;
  localparam logic [7:0] OP_POP_A = 8'h86;
  localparam logic [7:0] OP_POP_X = 8'h88;
  localparam logic [7:0] OP_POP_H = 8'h8a;
  localparam logic [7:0] OP_IMM16_LD = 8'h45;
  localparam logic [7:0] OP_IMM16_CP = 8'h65;
  localparam logic [7:0] OP_EMPTY_A = 8'h8d;
  localparam logic [7:0] OP_EMPTY_B = 8'hac;
  localparam logic [3:0] COL_BRBIT = 4'h0;
  localparam logic [3:0] COL_BITDIR = 4'h1;
  localparam logic [3:0] COL_REL = 4'h2;
  localparam logic [3:0] COL_RMW_DIR = 4'h3;
  localparam logic [3:0] COL_RMW_IX1 = 4'h6;
  localparam logic [3:0] COL_REG_DIR = 4'hb;
  localparam logic [3:0] COL_REG_IX1 = 4'he;
  localparam logic [7:0] VEC_PAGE = 8'hff;
  localparam logic [7:0] DIR_PAGE = 8'h00;
  localparam logic [7:0] VEC_RESET_IDX = 8'hfe;
  localparam logic [7:0] VEC_WAKE_IDX = 8'hfa;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  typedef enum logic [2:0] {
    CYC_FREE, CYC_FETCH, CYC_READ, CYC_WRITE, CYC_PUSH, CYC_POP, CYC_VECTOR, CYC_HALT
  } bus_cycle_t;
  typedef enum logic [3:0] {
    S_FETCH, S_OPR1, S_OPR2, S_FREE, S_WAIT, S_PUSH, S_POP, S_VEC_HI, S_VEC_LO
  } seq_state_t;
  typedef enum logic [2:0] {M_NONE, M_REL, M_DIR, M_IX1, M_BITREL, M_IMM16} opr_mode_t;
endpackage : cpu_decode_pkg

/* hw/cpu_opcode_decoder.sv */
// opcode decode and bus-cycle sequencing for the 8-bit core
//
// Overview of operation
// - 94 loads stack pointer with index minus one
// - 8F clears mask, halts until interrupt
// - free cycle is one bus read cycle
// - program fetch reads next sequential program byte
// - push writes one byte, stack pointer adjusts
// - pop reads one byte, stack pointer adjusts
// - vectors read from top page, high first
// - relative offset signed, added to next instruction
// - direct address has zero upper byte
// - byte index offset zero-extended onto index pair
// - bit number field selects bit 0-7
// - two immediate bytes form one 16-bit operand
// - prebyte 9E selects second opcode page
`timescale 1ns/1ps
`default_nettype none
module cpu_opcode_decoder (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] rd_data,
  input wire logic irq_req,
  input wire logic [15:0] index_pair,
  input wire logic [7:0] push_data,
  output logic [15:0] bus_addr_q,
  output cpu_decode_pkg::bus_cycle_t bus_cycle_q,
  output logic bus_rd_q,
  output logic bus_wr_q,
  output logic [7:0] bus_wdata_q,
  output logic [7:0] opcode_q,
  output logic page2_q,
  output logic [15:0] stack_pointer_q,
  output logic int_mask_q,
  output logic halted_q,
  output logic illegal_rst_q,
  output logic decode_done_q,
  output logic [15:0] eff_addr_q,
  output logic [15:0] branch_target_q,
  output logic [7:0] bit_mask_q,
  output logic [15:0] imm16_q,
  output logic [7:0] pop_data_q
);
  cpu_decode_pkg::seq_state_t state_q, state_d;
  cpu_decode_pkg::opr_mode_t mode_q, mode_d, mode_dec;
  cpu_decode_pkg::bus_cycle_t cyc_d;
  logic [15:0] pc_q, pc_d, sp_d, eff_d, tgt_d, imm_d, addr_d;
  logic [7:0] op_d, bm_d, hi_q, hi_d, vhi_q, vhi_d, vidx_q, vidx_d, pop_d, wd_d;
  logic pg2_d, mask_d, ill_d, done_d, wait_q, wait_d;

  // opcode classification of the byte on the read bus
  wire [3:0] col = rd_data[7:4];
  wire page1 = !page2_q;
  wire is_prebyte = page1 && (rd_data == cpu_decode_pkg::OP_PAGE2);
  wire is_txs = page1 && (rd_data == cpu_decode_pkg::OP_IDX_TO_SP);
  wire is_wait = page1 && (rd_data == cpu_decode_pkg::OP_WAIT_INT);
  wire is_illegal = page1 && (rd_data == cpu_decode_pkg::OP_EMPTY_A
    || rd_data == cpu_decode_pkg::OP_EMPTY_B);
  wire is_push = page1 && (rd_data == cpu_decode_pkg::OP_PUSH_A
    || rd_data == cpu_decode_pkg::OP_PUSH_X || rd_data == cpu_decode_pkg::OP_PUSH_H);
  wire is_pop = page1 && (rd_data == cpu_decode_pkg::OP_POP_A
    || rd_data == cpu_decode_pkg::OP_POP_X || rd_data == cpu_decode_pkg::OP_POP_H);
  wire is_imm16 = (rd_data == cpu_decode_pkg::OP_IMM16_LD)
    || (rd_data == cpu_decode_pkg::OP_IMM16_CP);
  wire is_rel = (col == cpu_decode_pkg::COL_REL) || (rd_data == cpu_decode_pkg::OP_BSR);
  wire is_dir = (col == cpu_decode_pkg::COL_BITDIR) || (col == cpu_decode_pkg::COL_RMW_DIR)
    || (col == cpu_decode_pkg::COL_REG_DIR);
  wire is_ix1 = (col == cpu_decode_pkg::COL_RMW_IX1) || (col == cpu_decode_pkg::COL_REG_IX1);
  wire is_brbit = (col == cpu_decode_pkg::COL_BRBIT);
  wire is_bitop = (opcode_q[7:4] == cpu_decode_pkg::COL_BITDIR) || (opcode_q[7:4] == cpu_decode_pkg::COL_BRBIT);

  // operand form selection
  assign mode_dec = !page1 ? cpu_decode_pkg::M_NONE :
                    is_imm16 ? cpu_decode_pkg::M_IMM16 :
                    is_rel ? cpu_decode_pkg::M_REL :
                    is_brbit ? cpu_decode_pkg::M_BITREL :
                    is_dir ? cpu_decode_pkg::M_DIR :
                    is_ix1 ? cpu_decode_pkg::M_IX1 : cpu_decode_pkg::M_NONE;

  // address arithmetic for the operand forms
  wire [15:0] pc_next = pc_q + cpu_decode_pkg::ONE16;
  wire [15:0] rel_target = pc_next + {{8{rd_data[7]}}, rd_data};
  wire [15:0] dir_addr = {cpu_decode_pkg::DIR_PAGE, rd_data};
  wire [15:0] ix1_addr = index_pair + {8'h00, rd_data};
  wire [2:0] bit_sel = opcode_q[3:1];
  wire [7:0] bit_onehot = cpu_decode_pkg::BIT0_MASK << bit_sel;
  wire [15:0] sp_dec = stack_pointer_q - cpu_decode_pkg::ONE16;
  wire [15:0] sp_inc = stack_pointer_q + cpu_decode_pkg::ONE16;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    sp_d = stack_pointer_q;
    mode_d = mode_q;
    op_d = opcode_q;
    pg2_d = page2_q;
    mask_d = int_mask_q;
    eff_d = eff_addr_q;
    tgt_d = branch_target_q;
    bm_d = bit_mask_q;
    imm_d = imm16_q;
    hi_d = hi_q;
    vhi_d = vhi_q;
    vidx_d = vidx_q;
    pop_d = pop_data_q;
    wd_d = bus_wdata_q;
    wait_d = wait_q;
    ill_d = 1'b0;
    done_d = 1'b0;
    case (state_q)
      cpu_decode_pkg::S_FETCH: begin
        pc_d = pc_next;
        op_d = rd_data;
        pg2_d = 1'b0;
        if (is_prebyte) begin
          pg2_d = 1'b1;
        end else if (is_illegal) begin
          ill_d = 1'b1;
          vidx_d = cpu_decode_pkg::VEC_RESET_IDX;
          state_d = cpu_decode_pkg::S_VEC_HI;
        end else if (is_txs) begin
          state_d = cpu_decode_pkg::S_FREE;
        end else if (is_wait) begin
          mask_d = 1'b0;
          wait_d = 1'b1;
          state_d = cpu_decode_pkg::S_FREE;
        end else if (is_push) begin
          wd_d = push_data;
          state_d = cpu_decode_pkg::S_PUSH;
        end else if (is_pop) begin
          state_d = cpu_decode_pkg::S_POP;
        end else if (mode_dec != cpu_decode_pkg::M_NONE) begin
          mode_d = mode_dec;
          state_d = cpu_decode_pkg::S_OPR1;
        end else begin
          done_d = 1'b1;
        end
      end
      cpu_decode_pkg::S_FREE: begin
        if (wait_q) begin
          state_d = cpu_decode_pkg::S_WAIT;
        end else begin
          sp_d = index_pair - cpu_decode_pkg::ONE16;
          done_d = 1'b1;
          state_d = cpu_decode_pkg::S_FETCH;
        end
      end
      cpu_decode_pkg::S_WAIT: begin
        if (irq_req && !int_mask_q) begin
          vidx_d = cpu_decode_pkg::VEC_WAKE_IDX;
          mask_d = 1'b1;
          wait_d = 1'b0;
          state_d = cpu_decode_pkg::S_VEC_HI;
        end
      end
      cpu_decode_pkg::S_PUSH: begin
        sp_d = sp_dec;
        done_d = 1'b1;
        state_d = cpu_decode_pkg::S_FETCH;
      end
      cpu_decode_pkg::S_POP: begin
        pop_d = rd_data;
        sp_d = sp_inc;
        done_d = 1'b1;
        state_d = cpu_decode_pkg::S_FETCH;
      end
      cpu_decode_pkg::S_VEC_HI: begin
        vhi_d = rd_data;
        state_d = cpu_decode_pkg::S_VEC_LO;
      end
      cpu_decode_pkg::S_VEC_LO: begin
        pc_d = {vhi_q, rd_data};
        state_d = cpu_decode_pkg::S_FETCH;
      end
      cpu_decode_pkg::S_OPR1: begin
        pc_d = pc_next;
        state_d = cpu_decode_pkg::S_FETCH;
        done_d = 1'b1;
        case (mode_q)
          cpu_decode_pkg::M_REL: tgt_d = rel_target;
          cpu_decode_pkg::M_DIR: begin
            eff_d = dir_addr;
            if (is_bitop) bm_d = bit_onehot;
          end
          cpu_decode_pkg::M_IX1: eff_d = ix1_addr;
          cpu_decode_pkg::M_BITREL: begin
            eff_d = dir_addr;
            bm_d = bit_onehot;
            mode_d = cpu_decode_pkg::M_REL;
            done_d = 1'b0;
            state_d = cpu_decode_pkg::S_OPR2;
          end
          cpu_decode_pkg::M_IMM16: begin
            hi_d = rd_data;
            done_d = 1'b0;
            state_d = cpu_decode_pkg::S_OPR2;
          end
          default: state_d = cpu_decode_pkg::S_FETCH;
        endcase
      end
      cpu_decode_pkg::S_OPR2: begin
        pc_d = pc_next;
        done_d = 1'b1;
        state_d = cpu_decode_pkg::S_FETCH;
        if (mode_q == cpu_decode_pkg::M_IMM16) begin
          imm_d = {hi_q, rd_data};
        end else begin
          tgt_d = rel_target;
        end
      end
      default: state_d = cpu_decode_pkg::S_FETCH;
    endcase
  end

  // address and activity code of the next bus cycle
  always_comb begin
    addr_d = pc_d;
    cyc_d = cpu_decode_pkg::CYC_FETCH;
    case (state_d)
      cpu_decode_pkg::S_FREE: cyc_d = cpu_decode_pkg::CYC_FREE;
      cpu_decode_pkg::S_WAIT: cyc_d = cpu_decode_pkg::CYC_HALT;
      cpu_decode_pkg::S_PUSH: begin
        addr_d = stack_pointer_q;
        cyc_d = cpu_decode_pkg::CYC_PUSH;
      end
      cpu_decode_pkg::S_POP: begin
        addr_d = sp_inc;
        cyc_d = cpu_decode_pkg::CYC_POP;
      end
      cpu_decode_pkg::S_VEC_HI: begin
        addr_d = {cpu_decode_pkg::VEC_PAGE, vidx_d};
        cyc_d = cpu_decode_pkg::CYC_VECTOR;
      end
      cpu_decode_pkg::S_VEC_LO: begin
        addr_d = {cpu_decode_pkg::VEC_PAGE, vidx_q[7:1], 1'b1};
        cyc_d = cpu_decode_pkg::CYC_VECTOR;
      end
      default: cyc_d = cpu_decode_pkg::CYC_FETCH;
    endcase
  end

  // bus cycle registers; reset starts with the reset vector fetch
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cpu_decode_pkg::S_VEC_HI;
      bus_addr_q <= {cpu_decode_pkg::VEC_PAGE, cpu_decode_pkg::VEC_RESET_IDX};
      bus_cycle_q <= cpu_decode_pkg::CYC_VECTOR;
      bus_rd_q <= 1'b1;
      bus_wr_q <= 1'b0;
      halted_q <= 1'b0;
      vidx_q <= cpu_decode_pkg::VEC_RESET_IDX;
    end else begin
      state_q <= state_d;
      bus_addr_q <= addr_d;
      bus_cycle_q <= cyc_d;
      bus_rd_q <= (cyc_d != cpu_decode_pkg::CYC_PUSH) && (cyc_d != cpu_decode_pkg::CYC_HALT);
      bus_wr_q <= (cyc_d == cpu_decode_pkg::CYC_PUSH);
      halted_q <= (state_d == cpu_decode_pkg::S_WAIT);
      vidx_q <= vidx_d;
    end
  end

  // decode result registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pc_q, eff_addr_q, branch_target_q, imm16_q} <= '0;
      stack_pointer_q <= cpu_decode_pkg::SP_RESET;
      {opcode_q, bit_mask_q, hi_q, vhi_q, pop_data_q, bus_wdata_q} <= '0;
      mode_q <= cpu_decode_pkg::M_NONE;
      {page2_q, wait_q, illegal_rst_q, decode_done_q} <= '0;
      int_mask_q <= 1'b1;
    end else begin
      {pc_q, eff_addr_q, branch_target_q, imm16_q} <= {pc_d, eff_d, tgt_d, imm_d};
      stack_pointer_q <= sp_d;
      {opcode_q, bit_mask_q, hi_q, vhi_q, pop_data_q, bus_wdata_q} <=
        {op_d, bm_d, hi_d, vhi_d, pop_d, wd_d};
      mode_q <= mode_d;
      {page2_q, wait_q, illegal_rst_q, decode_done_q} <= {pg2_d, wait_d, ill_d, done_d};
      int_mask_q <= mask_d;
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire fetching = (state_q == cpu_decode_pkg::S_FETCH);

  a_txs_sp_load: assert property (fetching && is_txs |-> ##2
    (stack_pointer_q == $past(index_pair) - cpu_decode_pkg::ONE16))
    else $error("stack pointer not loaded from index pair minus one");
  a_wait_halts: assert property (fetching && is_wait |=> !int_mask_q ##1 halted_q)
    else $error("wait did not clear mask and halt");
  a_halt_holds: assert property (halted_q && !irq_req |=> halted_q)
    else $error("halt left without an interrupt");
  a_free_single_read: assert property (bus_cycle_q == cpu_decode_pkg::CYC_FREE |->
    bus_rd_q && !bus_wr_q ##1 bus_cycle_q != cpu_decode_pkg::CYC_FREE)
    else $error("free cycle not a single read");
  a_fetch_sequential: assert property (bus_cycle_q == cpu_decode_pkg::CYC_FETCH
    && $past(bus_cycle_q) == cpu_decode_pkg::CYC_FETCH |-> bus_addr_q == $past(bus_addr_q) + 16'h0001)
    else $error("program fetch not sequential");
  a_push_one_byte: assert property (bus_cycle_q == cpu_decode_pkg::CYC_PUSH |->
    bus_wr_q && bus_addr_q == stack_pointer_q ##1
    stack_pointer_q == $past(stack_pointer_q) - 16'h0001)
    else $error("push did not move stack pointer by one");
  a_pop_one_byte: assert property (bus_cycle_q == cpu_decode_pkg::CYC_POP |->
    bus_rd_q && bus_addr_q == stack_pointer_q + 16'h0001 ##1
    stack_pointer_q == $past(stack_pointer_q) + 16'h0001)
    else $error("pop did not move stack pointer by one");
  a_vector_high_first: assert property (state_q == cpu_decode_pkg::S_VEC_HI |->
    bus_addr_q[15:8] == cpu_decode_pkg::VEC_PAGE && !bus_addr_q[0] ##1
    bus_addr_q == $past(bus_addr_q) + 16'h0001 ##1
    bus_addr_q == {$past(rd_data, 2), $past(rd_data)})
    else $error("vector bytes out of order");
  a_direct_page: assert property (state_q == cpu_decode_pkg::S_OPR1
    && mode_q == cpu_decode_pkg::M_DIR |=> eff_addr_q == {8'h00, $past(rd_data)})
    else $error("direct address upper byte not zero");
  a_index_offset: assert property (state_q == cpu_decode_pkg::S_OPR1
    && mode_q == cpu_decode_pkg::M_IX1 |=>
    eff_addr_q == $past(index_pair) + {8'h00, $past(rd_data)})
    else $error("byte offset not zero-extended");
  a_illegal_reset: assert property (fetching && is_illegal |=> illegal_rst_q
    && bus_cycle_q == cpu_decode_pkg::CYC_VECTOR)
    else $error("empty opcode did not raise reset");

  c_txs_done: cover property (fetching && is_txs ##2 decode_done_q);
  c_wait_wake: cover property (halted_q ##1 state_q == cpu_decode_pkg::S_VEC_HI);
  c_push_pop: cover property (bus_cycle_q == cpu_decode_pkg::CYC_PUSH ##[1:20]
    bus_cycle_q == cpu_decode_pkg::CYC_POP);
  c_prebyte: cover property (page2_q ##1 decode_done_q);
endmodule : cpu_opcode_decoder
`default_nettype wire

/* tb/mem_model.sv */
// behavioural program, data and stack memory on the far side of the system bus
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic core_clk,
  input wire logic [15:0] bus_addr_q,
  input wire logic bus_rd_q,
  input wire logic bus_wr_q,
  input wire logic [7:0] bus_wdata_q,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:65535];
  // unwritten locations read as a no-operation opcode
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h9d;
    end
  end
  // zero-wait read; on cycles that do not read, the line shows junk, not the last byte
  assign rd_data = bus_rd_q ? mem[bus_addr_q] : ~mem[bus_addr_q];
  // one byte stored per write cycle
  always @(posedge core_clk) begin
    if (bus_wr_q) begin
      mem[bus_addr_q] <= bus_wdata_q;
    end
  end
endmodule : mem_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking testbench for the opcode decoder with a memory model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk;
  logic rst_n;
  logic [7:0] rd_data;
  logic irq_req;
  logic [15:0] index_pair;
  logic [7:0] push_data;
  logic [15:0] bus_addr_q;
  cpu_decode_pkg::bus_cycle_t bus_cycle_q;
  logic bus_rd_q;
  logic bus_wr_q;
  logic [7:0] bus_wdata_q;
  logic [7:0] opcode_q;
  logic page2_q;
  logic [15:0] stack_pointer_q;
  logic int_mask_q;
  logic halted_q;
  logic illegal_rst_q;
  logic decode_done_q;
  logic [15:0] eff_addr_q;
  logic [15:0] branch_target_q;
  logic [7:0] bit_mask_q;
  logic [15:0] imm16_q;
  logic [7:0] pop_data_q;
  int err_count;
  int n_compared;
  cpu_opcode_decoder cpu_opcode_decoder_inst (.core_clk(core_clk), .rst_n(rst_n),
    .rd_data(rd_data), .irq_req(irq_req), .index_pair(index_pair), .push_data(push_data),
    .bus_addr_q(bus_addr_q), .bus_cycle_q(bus_cycle_q), .bus_rd_q(bus_rd_q),
    .bus_wr_q(bus_wr_q), .bus_wdata_q(bus_wdata_q), .opcode_q(opcode_q), .page2_q(page2_q),
    .stack_pointer_q(stack_pointer_q), .int_mask_q(int_mask_q), .halted_q(halted_q),
    .illegal_rst_q(illegal_rst_q), .decode_done_q(decode_done_q), .eff_addr_q(eff_addr_q),
    .branch_target_q(branch_target_q), .bit_mask_q(bit_mask_q), .imm16_q(imm16_q),
    .pop_data_q(pop_data_q));
  mem_model mem_model_inst (.core_clk(core_clk), .bus_addr_q(bus_addr_q), .bus_rd_q(bus_rd_q),
    .bus_wr_q(bus_wr_q), .bus_wdata_q(bus_wdata_q), .rd_data(rd_data));
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // judge the bus cycle shown now, then step to the next falling edge
  task automatic cyc(input cpu_decode_pkg::bus_cycle_t c, input logic [15:0] a);
    n_compared++;
    if (bus_cycle_q !== c || bus_addr_q !== a) begin
      err_count++;
      $display("BAD bus cycle expected %s at %h seen %s at %h", c.name(), a,
        bus_cycle_q.name(), bus_addr_q);
    end
    @(negedge core_clk);
  endtask : cyc
  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    mem_model_inst.mem[a] = d;
  endtask : poke
  // reset with the reset vector aimed at start, then check the vector pair
  task automatic do_reset(input logic [15:0] start);
    poke(16'hfffe, start[15:8]);
    poke(16'hffff, start[7:0]);
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    chk("sp reset", 16'h00ff, stack_pointer_q);
    chk("mask reset", 16'h0001, 16'(int_mask_q));
    cyc(cpu_decode_pkg::CYC_VECTOR, 16'hfffe);
    cyc(cpu_decode_pkg::CYC_VECTOR, 16'hffff);
  endtask : do_reset
  task automatic t_push_pop();
    poke(16'h0100, cpu_decode_pkg::OP_PUSH_A);
    poke(16'h0101, cpu_decode_pkg::OP_POP_X);
    do_reset(16'h0100);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0100);
    chk("push strobe", 16'h0001, 16'(bus_wr_q));
    chk("push byte", 16'h005a, 16'(bus_wdata_q));
    cyc(cpu_decode_pkg::CYC_PUSH, 16'h00ff);
    chk("sp after push", 16'h00fe, stack_pointer_q);
    chk("single write", 16'h0000, 16'(bus_wr_q));
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0101);
    cyc(cpu_decode_pkg::CYC_POP, 16'h00ff);
    chk("sp after pop", 16'h00ff, stack_pointer_q);
    chk("popped byte", 16'h005a, 16'(pop_data_q));
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0102);
    $display("push and pop done");
  endtask : t_push_pop
  task automatic t_transfer();
    poke(16'h0100, cpu_decode_pkg::OP_IDX_TO_SP);
    do_reset(16'h0100);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0100);
    chk("opcode latched", 16'(cpu_decode_pkg::OP_IDX_TO_SP), 16'(opcode_q));
    chk("free cycle reads", 16'h0001, 16'(bus_rd_q));
    cyc(cpu_decode_pkg::CYC_FREE, 16'h0101);
    chk("sp from index", 16'h1233, stack_pointer_q);
    chk("transfer done", 16'h0001, 16'(decode_done_q));
    chk("mask kept", 16'h0001, 16'(int_mask_q));
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0101);
    $display("index transfer done");
  endtask : t_transfer
  task automatic t_addr_modes();
    poke(16'h0300, 8'hb6);
    poke(16'h0301, 8'h80);
    poke(16'h0302, 8'he6);
    poke(16'h0303, 8'hf0);
    poke(16'h0304, 8'h20);
    poke(16'h0305, 8'h80);
    // bit test and branch on bit 7 with the largest forward offset
    poke(16'h0306, 8'h0e);
    poke(16'h0307, 8'h44);
    poke(16'h0308, 8'h7f);
    do_reset(16'h0300);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0300);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0301);
    chk("direct address", 16'h0080, eff_addr_q);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0302);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0303);
    chk("byte offset address", 16'h1324, eff_addr_q);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0304);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0305);
    chk("branch target", 16'h0286, branch_target_q);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0306);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0307);
    chk("bit branch address", 16'h0044, eff_addr_q);
    chk("bit branch select", 16'h0080, 16'(bit_mask_q));
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0308);
    chk("forward branch target", 16'h0388, branch_target_q);
    $display("addressing modes done");
  endtask : t_addr_modes
  task automatic t_imm_bits();
    poke(16'h0400, cpu_decode_pkg::OP_IMM16_LD);
    poke(16'h0401, 8'hc3);
    poke(16'h0402, 8'h3c);
    for (int n = 0; n < 8; n++) begin
      poke(16'(16'h0403 + 2 * n), 8'(8'h10 + 2 * n));
      poke(16'(16'h0404 + 2 * n), 8'h40);
    end
    do_reset(16'h0400);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0400);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0401);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0402);
    chk("immediate pair", 16'hc33c, imm16_q);
    for (int n = 0; n < 8; n++) begin
      cyc(cpu_decode_pkg::CYC_FETCH, 16'(16'h0403 + 2 * n));
      cyc(cpu_decode_pkg::CYC_FETCH, 16'(16'h0404 + 2 * n));
      chk("bit select", 16'(8'h01 << n), 16'(bit_mask_q));
    end
    $display("immediates and bit numbers done");
  endtask : t_imm_bits
  task automatic t_page2();
    poke(16'h0600, cpu_decode_pkg::OP_PAGE2);
    poke(16'h0601, 8'h60);
    do_reset(16'h0600);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0600);
    chk("second page flag", 16'h0001, 16'(page2_q));
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0601);
    chk("second page cleared", 16'h0000, 16'(page2_q));
    // on the first page this byte would still want an offset fetch
    chk("second page done", 16'h0001, 16'(decode_done_q));
    $display("second page done");
  endtask : t_page2
  task automatic t_wait();
    poke(16'h0700, cpu_decode_pkg::OP_WAIT_INT);
    poke(16'hfffa, 8'h02);
    poke(16'hfffb, 8'h00);
    do_reset(16'h0700);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0700);
    cyc(cpu_decode_pkg::CYC_FREE, 16'h0701);
    chk("mask cleared", 16'h0000, 16'(int_mask_q));
    repeat (5) begin
      chk("halted", 16'h0001, 16'(halted_q));
      chk("halt code", 16'(cpu_decode_pkg::CYC_HALT), 16'(bus_cycle_q));
      @(negedge core_clk);
    end
    irq_req = 1'b1;
    @(negedge core_clk);
    irq_req = 1'b0;
    chk("woken", 16'h0000, 16'(halted_q));
    cyc(cpu_decode_pkg::CYC_VECTOR, 16'hfffa);
    cyc(cpu_decode_pkg::CYC_VECTOR, 16'hfffb);
    cyc(cpu_decode_pkg::CYC_FETCH, 16'h0200);
    $display("wait for interrupt done");
  endtask : t_wait
  task automatic t_illegal();
    logic [7:0] ops [2];
    ops[0] = cpu_decode_pkg::OP_EMPTY_A;
    ops[1] = cpu_decode_pkg::OP_EMPTY_B;
    for (int k = 0; k < 2; k++) begin
      poke(16'h0800, ops[k]);
      do_reset(16'h0800);
      cyc(cpu_decode_pkg::CYC_FETCH, 16'h0800);
      chk("illegal pulse", 16'h0001, 16'(illegal_rst_q));
      cyc(cpu_decode_pkg::CYC_VECTOR, 16'hfffe);
      chk("illegal pulse ends", 16'h0000, 16'(illegal_rst_q));
    end
    $display("illegal opcodes done");
  endtask : t_illegal
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // main sequence, inputs change on falling edges
  initial begin
    err_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    irq_req = 1'b0;
    index_pair = 16'h1234;
    push_data = 8'h5a;
    @(negedge core_clk);
    t_push_pop();
    t_transfer();
    t_addr_modes();
    t_imm_bits();
    t_page2();
    t_wait();
    t_illegal();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
